// *** design/psb_cfg.svh ***
// register map, field positions, reset values and timing constants of the protection stage
`ifndef PSB_CFG_SVH
`define PSB_CFG_SVH

`define PSB_CLK_HZ          50000000
`define PSB_TICK_MS         1
`define PSB_TICK_CLKS       (`PSB_CLK_HZ / 1000 * `PSB_TICK_MS)
`define PSB_STEP_MS         5
`define PSB_BLOCK_LEAD_MS   5

`define PSB_RESET_PCT       8'h61
`define PSB_FULL_PCT        8'h64

`define PSB_OFS_CTRL        8'h00
`define PSB_OFS_DELAY       8'h04
`define PSB_OFS_DIAL        8'h08
`define PSB_OFS_PICKUP      8'h0C
`define PSB_OFS_PARAM       8'h10
`define PSB_OFS_STATUS      8'h14
`define PSB_OFS_IRQSTAT     8'h18
`define PSB_OFS_IRQMASK     8'h1C
`define PSB_OFS_STAMP       8'h20
`define PSB_OFS_LASTEVT     8'h24

`define PSB_CTRL_TYPE       0
`define PSB_CTRL_SERIES     1
`define PSB_CTRL_CURVE_LO   2
`define PSB_CTRL_CURVE_HI   4

`define PSB_RST_DELAY       19'h00008
`define PSB_RST_DIAL        12'h005
`define PSB_RST_PICKUP      16'h0100
`define PSB_RST_PARAM       16'h0010

`define PSB_IRQ_START       0
`define PSB_IRQ_BLOCK       1
`define PSB_IRQ_TRIP        2

`define PSB_FIRST_PARAM     3'h4
`define PSB_SECOND_PARAM    3'h7
`define PSB_GAIN_NORMAL     16'h0046
`define PSB_GAIN_EXTREME    16'h0FA0
`define PSB_GAIN_VERY       16'h02A3
`define PSB_GAIN_LONG       16'h1770
`define PSB_GAIN_MODERATE   16'h0020

`endif

// *** design/psb_pkg.sv ***
// types shared by the protection stage files
package psb_pkg;
    typedef enum logic {DEFINITE_DELAY_MODE, INVERSE_DELAY_MODE} psb_delay_t;
    typedef enum logic {FIRST_SERIES, SECOND_SERIES} psb_series_t;
    typedef enum logic [1:0] {ST_IDLE, ST_STARTED, ST_INHIBITED, ST_TRIPPED} psb_state_t;
endpackage

// *** design/psb_inverse_acc.sv ***
// inverse-time integrator: trips when accumulated excess reaches dial x gain x setting
`timescale 1ns/1ps
module psb_inverse_acc
    import psb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        tick,
    input  wire logic        run,
    input  wire logic [15:0] meas,
    input  wire logic [15:0] pickupSet,
    input  wire logic [11:0] dial,
    input  wire logic [15:0] gain,
    output logic             done
);
    logic [47:0] acc;
    logic [47:0] limit;

    // delay = dial*gain/(ratio-1) ticks; integrating avoids a divider
    assign limit = 48'(dial) * 48'(gain) * 48'(pickupSet);

    always_ff @(posedge clk)
    begin
        if (rst || !run)
            acc <= 48'h0;
        else if (tick && meas > pickupSet)
            acc <= acc + 48'(meas - pickupSet);
    end

    always_ff @(posedge clk)
    begin
        if (rst || !run)
            done <= 1'b0;
        else
            done <= (acc >= limit);
    end
endmodule // psb_inverse_acc

// *** design/psb_stage.sv ***
// protection stage: blocking, start, operate-delay timer, events, ahb-lite registers
`timescale 1ns/1ps
`include "psb_cfg.svh"
module psb_stage
    import psb_pkg::*;
#(
    parameter int TICK_CLKS = `PSB_TICK_CLKS
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [15:0] measIn,
    input  wire logic        blockIn,
    input  wire logic [2:0]  faultType,
    output logic             start,
    output logic             stageInhibited,
    output logic             trip,
    output logic             evtValid,
    output logic [31:0]      evtTime,
    output logic [15:0]      evtCurrent,
    output logic [2:0]       evtFault,
    output logic             irq
);
    psb_state_t  state;
    psb_state_t  next_state;
    logic [31:0] divCnt;
    logic        tick;
    logic [31:0] stamp;
    logic        pickAct;
    logic        newPick;
    logic        blockSample;
    logic [20:0] elapsedMs;
    logic [21:0] delayMs;
    logic        tripNow;
    logic        invDone;
    logic [15:0] startCurrent;
    logic [15:0] curveGain;
    psb_delay_t  delayType;
    psb_series_t series;
    logic [2:0]  curveSel;
    logic [18:0] defDelay;
    logic [11:0] dial;
    logic [15:0] pickupSet;
    logic [15:0] paramA;
    logic [2:0]  irqStat;
    logic [2:0]  irqMask;
    logic [2:0]  irqSet;
    logic        wrPend;
    logic [7:0]  wrAddr;

    function automatic logic pickEval(input logic prev, input logic [15:0] m,
                                      input logic [15:0] s);
        logic [23:0] mScaled;
        logic [23:0] sScaled;
        mScaled = 24'(m) * 24'(`PSB_FULL_PCT);
        sScaled = 24'(s) * 24'(`PSB_RESET_PCT);
        if (prev)
            pickEval = (mScaled > sScaled);
        else
            pickEval = (m > s);
    endfunction

    // unknown codes fall back to the normal gain so an illegal selection still trips; parametric codes use userA
    function automatic logic [15:0] gainOf(input psb_series_t ser, input logic [2:0] cv,
                                           input logic [15:0] userA);
        unique case (cv)
            3'h1:    gainOf = (ser == FIRST_SERIES) ? `PSB_GAIN_EXTREME : `PSB_GAIN_VERY;
            3'h2:    gainOf = (ser == FIRST_SERIES) ? `PSB_GAIN_VERY : `PSB_GAIN_EXTREME;
            3'h3:    gainOf = `PSB_GAIN_LONG;
            3'h4:    gainOf = (ser == FIRST_SERIES) ? userA : `PSB_GAIN_MODERATE;
            3'h5:    gainOf = (ser == FIRST_SERIES) ? `PSB_GAIN_NORMAL : `PSB_GAIN_VERY;
            3'h6:    gainOf = (ser == FIRST_SERIES) ? `PSB_GAIN_NORMAL : `PSB_GAIN_EXTREME;
            3'h7:    gainOf = (ser == FIRST_SERIES) ? `PSB_GAIN_NORMAL : userA;
            default: gainOf = `PSB_GAIN_NORMAL;
        endcase
    endfunction

    // processing cycle timebase
    always_ff @(posedge clk)
    begin
        if (rst || divCnt == 32'(TICK_CLKS - 1))
            divCnt <= 32'h0;
        else
            divCnt <= divCnt + 32'h1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            tick <= 1'b0;
        else
            tick <= (divCnt == 32'(TICK_CLKS - 1));
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            stamp <= 32'h0;
        else if (tick)
            stamp <= stamp + 32'h1;
    end

    assign delayMs   = 22'(defDelay) * 22'(`PSB_STEP_MS);
    assign curveGain = gainOf(series, curveSel, paramA);
    assign newPick   = pickEval(pickAct, measIn, pickupSet);

    always_comb
    begin
        if (delayType == DEFINITE_DELAY_MODE)
            tripNow = (22'(elapsedMs) + 22'h1 >= delayMs);
        else
            tripNow = invDone && (22'(elapsedMs) + 22'h1 >= delayMs);
    end

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE, ST_INHIBITED:
                if (newPick && blockIn)
                    next_state = ST_INHIBITED;
                else if (newPick)
                    next_state = tripNow ? ST_TRIPPED : ST_STARTED;
                else
                    next_state = ST_IDLE;
            ST_STARTED, ST_TRIPPED:
                if (newPick && blockIn)
                    next_state = ST_INHIBITED;
                else if (!newPick)
                    next_state = ST_IDLE;
                else if (tripNow)
                    next_state = ST_TRIPPED;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            state <= ST_IDLE;
        else if (tick)
            state <= next_state;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pickAct     <= 1'b0;
            blockSample <= 1'b0;
        end
        else if (tick)
        begin
            pickAct     <= newPick;
            blockSample <= blockIn;
        end
    end

    // timer restarts from zero whenever the stage leaves the started states
    always_ff @(posedge clk)
    begin
        if (rst)
            elapsedMs <= 21'h0;
        else if (tick)
        begin
            if (next_state == ST_STARTED && state == ST_STARTED)
                elapsedMs <= elapsedMs + 21'h1;
            else if (next_state != ST_TRIPPED)
                elapsedMs <= 21'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            start          <= 1'b0;
            stageInhibited <= 1'b0;
            trip           <= 1'b0;
        end
        else if (tick)
        begin
            start          <= (next_state == ST_STARTED || next_state == ST_TRIPPED);
            stageInhibited <= (next_state == ST_INHIBITED);
            trip           <= (next_state == ST_TRIPPED);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            startCurrent <= 16'h0;
        else if (tick && (state == ST_IDLE || state == ST_INHIBITED) && newPick && !blockIn)
            startCurrent <= measIn;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            evtValid   <= 1'b0;
            evtTime    <= 32'h0;
            evtCurrent <= 16'h0;
            evtFault   <= 3'h0;
        end
        else if (tick && next_state == ST_INHIBITED && state != ST_INHIBITED)
        begin
            evtValid   <= 1'b1;
            evtTime    <= stamp;
            evtCurrent <= (state == ST_IDLE) ? measIn : startCurrent;
            evtFault   <= faultType;
        end
        else
            evtValid <= 1'b0;
    end

    psb_inverse_acc u_inv (
        .clk       (clk),
        .rst       (rst),
        .tick      (tick),
        .run       (delayType == INVERSE_DELAY_MODE && state == ST_STARTED),
        .meas      (measIn),
        .pickupSet (pickupSet),
        .dial      (dial),
        .gain      (curveGain),
        .done      (invDone)
    );

    assign irqSet = {tick && next_state == ST_TRIPPED && state != ST_TRIPPED,
                     tick && next_state == ST_INHIBITED && state != ST_INHIBITED,
                     tick && (next_state == ST_STARTED || next_state == ST_TRIPPED)
                          && (state == ST_IDLE || state == ST_INHIBITED)};

    // ahb-lite slave, zero wait states, writes land in the data phase
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wrPend <= 1'b0;
            wrAddr <= 8'h0;
        end
        else if (hready)
        begin
            wrPend <= hsel && htrans[1] && hwrite;
            wrAddr <= haddr[7:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            delayType <= DEFINITE_DELAY_MODE;
            series    <= FIRST_SERIES;
            curveSel  <= 3'h0;
            defDelay  <= `PSB_RST_DELAY;
            dial      <= `PSB_RST_DIAL;
            pickupSet <= `PSB_RST_PICKUP;
            paramA    <= `PSB_RST_PARAM;
            irqMask   <= 3'h0;
        end
        else if (wrPend)
        begin
            unique case (wrAddr)
                `PSB_OFS_CTRL:
                begin
                    delayType <= psb_delay_t'(hwdata[`PSB_CTRL_TYPE]);
                    series    <= psb_series_t'(hwdata[`PSB_CTRL_SERIES]);
                    curveSel  <= hwdata[`PSB_CTRL_CURVE_HI:`PSB_CTRL_CURVE_LO];
                end
                `PSB_OFS_DELAY:   defDelay  <= hwdata[18:0];
                `PSB_OFS_DIAL:    dial      <= hwdata[11:0];
                `PSB_OFS_PICKUP:  pickupSet <= hwdata[15:0];
                `PSB_OFS_PARAM:   paramA    <= hwdata[15:0];
                `PSB_OFS_IRQMASK: irqMask   <= hwdata[2:0];
                default:          ;
            endcase
        end
    end

    // a new event wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            irqStat <= 3'h0;
        else if (wrPend && wrAddr == `PSB_OFS_IRQSTAT)
            irqStat <= (irqStat & ~hwdata[2:0]) | irqSet;
        else
            irqStat <= irqStat | irqSet;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(irqStat & irqMask);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            hrdata <= 32'h0;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            unique case (haddr[7:0])
                `PSB_OFS_CTRL:    hrdata <= {27'h0, curveSel, series, delayType};
                `PSB_OFS_DELAY:   hrdata <= {13'h0, defDelay};
                `PSB_OFS_DIAL:    hrdata <= {20'h0, dial};
                `PSB_OFS_PICKUP:  hrdata <= {16'h0, pickupSet};
                `PSB_OFS_PARAM:   hrdata <= {16'h0, paramA};
                `PSB_OFS_STATUS:  hrdata <= {27'h0, blockSample, pickAct, trip,
                                             stageInhibited, start};
                `PSB_OFS_IRQSTAT: hrdata <= {29'h0, irqStat};
                `PSB_OFS_IRQMASK: hrdata <= {29'h0, irqMask};
                `PSB_OFS_STAMP:   hrdata <= stamp;
                `PSB_OFS_LASTEVT: hrdata <= {13'h0, evtFault, evtCurrent};
                default:          hrdata <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    sequence sFreshPick;
        tick && state == ST_IDLE && newPick;
    endsequence

    sequence sBlockedPick;
        tick && newPick && blockIn;
    endsequence

    a_start_raise: assert property (@(posedge clk) disable iff (rst)
        sFreshPick and (tick && !blockIn) |=> start && !stageInhibited)
        else $error("start not raised on clear pick-up");

    a_block_inhibit: assert property (@(posedge clk) disable iff (rst)
        sBlockedPick |=> stageInhibited && !trip)
        else $error("stage_inhibited pick-up not inhibited");

    a_block_clears: assert property (@(posedge clk) disable iff (rst)
        sBlockedPick and (tick && start) |=> !start ##1 elapsedMs == 21'h0)
        else $error("blocking left start or timer running");

    a_block_event: assert property (@(posedge clk) disable iff (rst)
        sBlockedPick and (tick && state != ST_INHIBITED) |=> evtValid && evtTime == $past(stamp))
        else $error("blocking event missing");

    a_instant_trip: assert property (@(posedge clk) disable iff (rst)
        sFreshPick and (tick && !blockIn && delayType == DEFINITE_DELAY_MODE
        && defDelay == 19'h0) |=> trip && start)
        else $error("instant mode did not trip with start");

    a_dt_timing: assert property (@(posedge clk) disable iff (rst)
        $rose(trip) && delayType == DEFINITE_DELAY_MODE |-> $past(tripNow))
        else $error("definite trip before delay");

    a_inverse_delay_mode_floor: assert property (@(posedge clk) disable iff (rst)
        $rose(trip) && delayType == INVERSE_DELAY_MODE
        |-> $past(invDone) && 22'($past(elapsedMs)) + 22'h1 >= delayMs)
        else $error("inverse trip below floor");

    a_release_clear: assert property (@(posedge clk) disable iff (rst)
        tick && !newPick |=> !start && !trip ##1 elapsedMs == 21'h0)
        else $error("release left stage active");

    a_irq_level: assert property (@(posedge clk) disable iff (rst)
        |(irqStat & irqMask) |=> irq)
        else $error("interrupt not raised");
endmodule // psb_stage

// *** tb/psb_partner.sv ***
// pick-up source and blocking matrix model driving the stage inputs
`timescale 1ns/1ps
module psb_partner
(
    input  wire logic   clk,
    output logic [15:0] measIn,
    output logic        blockIn,
    output logic [2:0]  faultType
);
    initial
    begin
        measIn    = 16'h0000;
        blockIn   = 1'b0;
        faultType = 3'h0;
    end
    // levels move only after an edge so a tick never sees a half-changed set
    // blocking is always raised many ticks before the delay would expire
    task drive(input logic [15:0] m, input logic b, input logic [2:0] f);
        @(posedge clk);
        measIn    <= m;
        blockIn   <= b;
        faultType <= f;
    endtask
endmodule // psb_partner

// *** tb/protection_stage_blocking_and_delay_tb.sv ***
// self-checking bench for the protection stage
`timescale 1ns/1ps
`include "psb_cfg.svh"
module protection_stage_blocking_and_delay_tb;
    // short tick keeps each 5 ms step to 50 clocks
    localparam int TC = 10;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, evtTime, rd, e1;
    logic [15:0] evtCurrent, measIn;
    logic [2:0]  evtFault, faultType;
    logic        hreadyout, hresp, start, stageInhibited, trip, evtValid, irq, blockIn;
    int          miscompares = 0;
    int          n_checks = 0;
    int          n, n2;
    int          clkCount = 0;
    always #10 clk = ~clk;
    always @(posedge clk) clkCount <= clkCount + 1;
    psb_stage #(.TICK_CLKS(TC)) dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .measIn(measIn),
        .blockIn(blockIn), .faultType(faultType), .start(start),
        .stageInhibited(stageInhibited), .trip(trip), .evtValid(evtValid), .evtTime(evtTime),
        .evtCurrent(evtCurrent), .evtFault(evtFault), .irq(irq));
    psb_partner part (.clk(clk), .measIn(measIn), .blockIn(blockIn), .faultType(faultType));
    task results();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // counts edges until the chosen output is seen high: 0 start 1 trip 2 inhibited 3 event
    task waitEdge(input int which, output int cyc);
        cyc = 0;
        do
        begin
            @(posedge clk);
            cyc++;
        end
        while ((which == 0 ? start : which == 1 ? trip : which == 2 ? stageInhibited
                : evtValid) !== 1'b1 && cyc < 4000);
        if (cyc >= 4000)
            miscompares++;
    endtask
    task idle();
        part.drive(16'h0000, 1'b0, 3'h0);
        repeat (3 * TC) @(posedge clk);
    endtask
    task t_reset();
        rdc(`PSB_OFS_CTRL, 32'h0);
        rdc(`PSB_OFS_DELAY, 32'h8);
        rdc(`PSB_OFS_DIAL, 32'h5);
        rdc(`PSB_OFS_PICKUP, 32'h100);
        rdc(`PSB_OFS_PARAM, 32'h10);
        rdc(`PSB_OFS_IRQMASK, 32'h0);
        rdc(8'h40, 32'h0);
        check({31'h0, hresp}, 32'h0);
    endtask
    task t_curves();
        for (int s = 0; s < 2; s++)
            for (int c = 0; c < 8; c++)
            begin
                ahb(1'b1, `PSB_OFS_CTRL, 32'(c * 4 + s * 2 + 1));
                rdc(`PSB_OFS_CTRL, 32'(c * 4 + s * 2 + 1));
            end
        ahb(1'b1, `PSB_OFS_CTRL, 32'h0);
    endtask
    task t_definite();
        ahb(1'b1, `PSB_OFS_DELAY, 32'h2);
        part.drive(16'h0200, 1'b0, 3'h0);
        waitEdge(0, n);
        check({start, trip}, 32'h2);
        waitEdge(1, n2);
        check(n2, 2 * `PSB_STEP_MS * TC);
        idle();
        ahb(1'b1, `PSB_OFS_DELAY, 32'h0);
        part.drive(16'h0200, 1'b0, 3'h0);
        waitEdge(0, n);
        check({start, trip}, 32'h3);
        idle();
    endtask
    task t_hysteresis();
        ahb(1'b1, `PSB_OFS_DELAY, 32'h2);
        part.drive(16'h0101, 1'b0, 3'h0);
        waitEdge(0, n);
        part.drive(16'h00F9, 1'b0, 3'h0);
        repeat (5 * TC) @(posedge clk);
        check({start, trip}, 32'h2);
        part.drive(16'h00F8, 1'b0, 3'h0);
        repeat (2 * TC) @(posedge clk);
        check({start, trip}, 32'h0);
        part.drive(16'h0101, 1'b0, 3'h0);
        waitEdge(0, n);
        waitEdge(1, n2);
        check(n2, 2 * `PSB_STEP_MS * TC);
        idle();
    endtask
    task t_block();
        ahb(1'b1, `PSB_OFS_IRQSTAT, 32'h7);
        ahb(1'b1, `PSB_OFS_IRQMASK, 32'h2);
        part.drive(16'h0300, 1'b1, 3'h3);
        waitEdge(3, n);
        check({evtFault, evtCurrent}, 32'h30300);
        e1 = evtTime;
        n2 = clkCount;
        waitEdge(2, n);
        check({start, stageInhibited}, 32'h1);
        idle();
        ahb(1'b1, `PSB_OFS_DELAY, 32'h4);
        part.drive(16'h0280, 1'b0, 3'h0);
        waitEdge(0, n);
        repeat (5 * TC) @(posedge clk);
        // blocking lands 14 ms ahead of the 20 ms expiry
        part.drive(16'h0300, 1'b1, 3'h5);
        waitEdge(3, n);
        check({evtFault, evtCurrent}, 32'h50280);
        check(evtTime - e1, (clkCount - n2) / TC);
        repeat (2) @(posedge clk);
        check({start, stageInhibited}, 32'h1);
        repeat (25 * TC) @(posedge clk);
        check({trip, irq}, 32'h1);
        rdc(`PSB_OFS_STATUS, 32'h1A);
        rdc(`PSB_OFS_IRQSTAT, 32'h3);
        ahb(1'b1, `PSB_OFS_IRQMASK, 32'h0);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        ahb(1'b1, `PSB_OFS_IRQMASK, 32'h2);
        repeat (2) @(posedge clk);
        check(irq, 1'b1);
        ahb(1'b1, `PSB_OFS_IRQSTAT, 32'h2);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        // block released with pick-up held: timing restarts from zero
        part.drive(16'h0300, 1'b0, 3'h5);
        waitEdge(0, n);
        waitEdge(1, n2);
        check(n2, 4 * `PSB_STEP_MS * TC);
        idle();
    endtask
    // gains are arbitrary, so only the ordering of delays, the floor and the one-tick parametric case are exact
    task t_inverse();
        ahb(1'b1, `PSB_OFS_DELAY, 32'h0);
        ahb(1'b1, `PSB_OFS_CTRL, 32'h1);
        part.drive(16'hFFFF, 1'b0, 3'h0);
        waitEdge(0, n);
        waitEdge(1, n);
        idle();
        part.drive(16'h1100, 1'b0, 3'h0);
        waitEdge(0, n2);
        waitEdge(1, n2);
        check(n2 > n && n2 < 4000, 1'b1);
        idle();
        ahb(1'b1, `PSB_OFS_DELAY, 32'h4);
        part.drive(16'hFFFF, 1'b0, 3'h0);
        waitEdge(0, n);
        waitEdge(1, n);
        check(n, 4 * `PSB_STEP_MS * TC);
        idle();
        // parametric gain of 0x10 is passed after one integration tick
        ahb(1'b1, `PSB_OFS_DELAY, 32'h0);
        ahb(1'b1, `PSB_OFS_CTRL, 32'h11);
        part.drive(16'hFFFF, 1'b0, 3'h0);
        waitEdge(0, n2);
        waitEdge(1, n2);
        check(n2, 2 * TC);
        idle();
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_curves();
        t_definite();
        t_hysteresis();
        t_block();
        t_inverse();
        results();
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        miscompares++;
        results();
    end
endmodule // protection_stage_blocking_and_delay_tb
